// *** src/driver_operating_mode_fsm.sv ***
/*
  Operating-mode state machine of a single-channel gate driver: classifies
  fault events, moves among seven modes, starts emergency turn-offs, runs
  the verification watchdog and drives the two fault outputs.
  Assumes commands arrive as decoded 16-bit words with a one-cycle strobe,
  and that pins have already been brought into the mclk domain by the caller
  except where synchronised here.
*/
// Operation
// - class A: saturation, overcurrent, enable loss, tristate
// - class A: active->configured, weak->verification
// - class A output only on transition, tristate excepted
// - class A sets flag, keeps configuration
// - class B: supplies, supervision, verification timeout
// - class B enters error mode from anywhere
// - class B output only on transition
// - class C flagged, mode unchanged
// - emergency turn-off on A (not tristate alone), B or reset
// - re-enable refused 256 cycles after turn-off
// - ready high while no primary reset
// - enabled only in active or weak active
// - reset to default; clear sticky leaves error
// - enter configuration from default or error
// - exit configuration goes to configured mode
// - enable rising in configured enters active
// - enter verification from configuration mode
// - watchdog from verification entry raises class B
// - enable rising in verification enters weak active
// - fault outputs coincide with mode transition
// - near-simultaneous A and B both handled
// - commands accepted while failure persists
// - command words 1880, 1140, 1220 hex
// - invalid mode command discarded, SPI error flagged
// - mode readable in status mode field
`timescale 1ns/1ps
`include "opmode_consts.svh"

module driver_operating_mode_fsm #(
  parameter int VERIFY_TIMEOUT_CYCLES = `VERIFY_TIMEOUT_CYCLES,
  parameter int REENABLE_BLOCK_CYCLES = `REENABLE_BLOCK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic primary_reset,
  // host command port
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic clear_sticky_bit,
  // pins
  input wire logic enable_input,
  input wire logic pwm_input,
  input wire opmode_pkg::fault_in_t faults,
  // configuration
  input wire logic tertiary_overvoltage_enable,
  // fault notifications and ready
  output logic class_a_fault_out,
  output logic class_b_fault_out,
  output logic ready_out,
  // output stage control
  output logic gate_on,
  output logic gate_weak,
  output logic gate_tristate,
  output opmode_pkg::turn_off_t turn_off_req,
  // status
  output logic [2:0] mode_field,
  output opmode_pkg::flags_t status_flags,
  output logic reenable_blocked
);
  import opmode_pkg::*;

  typedef enum logic [2:0] {
    ST_DEFAULT,
    ST_ERROR,
    ST_CONFIGURATION,
    ST_CONFIGURED,
    ST_ACTIVE,
    ST_VERIFICATION,
    ST_WEAK_ACTIVE
  } mode_t;

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  // pins are asynchronous to mclk; second stage is the only reader of the first
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] sync1_q, sync2_q;
  logic en_prev_q;
  logic [NSYNC-1:0] raw_pins;
  assign raw_pins = {enable_input, pwm_input, faults};

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      en_prev_q <= 1'b0;
    end else begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      en_prev_q <= sync2_q[NSYNC-1];
    end
  end

  logic en_s, pwm_s;
  fault_in_t f;
  assign en_s = sync2_q[NSYNC-1];
  assign pwm_s = sync2_q[NSYNC-2];
  assign f = fault_in_t'(sync2_q[NSYNC-3:0]);

  logic en_rise, en_fall;
  assign en_rise = en_s && !en_prev_q;
  assign en_fall = !en_s && en_prev_q;

  // ***************************************************************
  // event classification
  // ***************************************************************
  logic wd_expired;
  logic ev_safe, ev_tristate, ev_a, ev_a_eto, ev_b_cond, ev_b;
  assign ev_safe = f.collector_saturation_fault | f.overcurrent_fault;
  assign ev_tristate = f.stage_monitor_tristate | f.output_disable_input;
  assign ev_a_eto = ev_safe | en_fall;
  assign ev_a = ev_a_eto | ev_tristate;
  // tertiary overvoltage only counts when its enable is set
  assign ev_b_cond = f.secondary_supply_undervoltage | f.secondary_supply_overvoltage
    | f.tertiary_supply_undervoltage | (f.tertiary_supply_overvoltage & tertiary_overvoltage_enable)
    | f.supervision_error;
  assign ev_b = ev_b_cond | wd_expired;

  // command decode
  function automatic logic is_mode_cmd(input logic [15:0] w);
    is_mode_cmd = (w == `CMD_ENTER_CFG) || (w == `CMD_ENTER_VER) || (w == `CMD_EXIT_CFG);
  endfunction

  // ***************************************************************
  // mode state machine
  // ***************************************************************
  mode_t mode_q, mode_d;
  logic cfg_pending_q, cfg_pending_d;
  logic fa_d, fb_d, spi_err_d, wd_start;
  turn_off_t toff_d;

  always_comb begin
    mode_d = mode_q;
    cfg_pending_d = cfg_pending_q;
    fa_d = 1'b0;
    fb_d = 1'b0;
    spi_err_d = 1'b0;
    wd_start = 1'b0;
    toff_d = TOFF_NONE;
    // commands first, so a persisting failure still overrides below
    if (cmd_valid && is_mode_cmd(cmd_word)) begin
      case (mode_q)
        ST_DEFAULT: begin
          if (cmd_word == `CMD_ENTER_CFG) begin
            mode_d = ST_CONFIGURATION;
          end else begin
            spi_err_d = 1'b1;
          end
        end
        ST_ERROR: begin
          // only parks the request while class B conditions are still present
          if (cmd_word == `CMD_ENTER_CFG && !ev_b) begin
            mode_d = ST_CONFIGURATION;
          end else if (cmd_word == `CMD_ENTER_CFG) begin
            cfg_pending_d = 1'b1;
          end else begin
            spi_err_d = 1'b1;
          end
        end
        ST_CONFIGURATION: begin
          if (cmd_word == `CMD_EXIT_CFG) begin
            mode_d = ST_CONFIGURED;
          end else if (cmd_word == `CMD_ENTER_VER) begin
            mode_d = ST_VERIFICATION;
            wd_start = 1'b1;
          end else begin
            spi_err_d = 1'b1;
          end
        end
        default: begin
          spi_err_d = 1'b1;
        end
      endcase
    end
    // pending enter-configuration waits for class B conditions to clear
    if (mode_q == ST_ERROR && cfg_pending_q && !ev_b) begin
      mode_d = ST_CONFIGURATION;
      cfg_pending_d = 1'b0;
    end else if (mode_q == ST_ERROR && clear_sticky_bit && !ev_b && !cfg_pending_d && mode_d == ST_ERROR) begin
      mode_d = ST_DEFAULT;
    end
    if (mode_q != ST_ERROR) begin
      cfg_pending_d = 1'b0;
    end
    // enable rising edge, blocked right after an emergency turn-off
    // a class A still present keeps the device disabled
    if (en_rise && !reenable_blocked && !ev_a) begin
      if (mode_q == ST_CONFIGURED) begin
        mode_d = ST_ACTIVE;
      end else if (mode_q == ST_VERIFICATION) begin
        mode_d = ST_WEAK_ACTIVE;
      end
    end
    // class A; tristate alone does no turn-off
    if (ev_a_eto) begin
      toff_d = ev_safe ? TOFF_SAFE : TOFF_REGULAR;
    end
    if (ev_a) begin
      if (mode_q == ST_ACTIVE) begin
        mode_d = ST_CONFIGURED;
        fa_d = 1'b1;
      end else if (mode_q == ST_WEAK_ACTIVE) begin
        mode_d = ST_VERIFICATION;
        fa_d = 1'b1;
      end else if (ev_tristate) begin
        fa_d = 1'b1;
      end
    end
    // class B wins over A in the same cycle; the class A turn-off kind is kept
    if (ev_b) begin
      if (toff_d == TOFF_NONE) begin
        toff_d = TOFF_REGULAR;
      end
      if (mode_q != ST_ERROR) begin
        mode_d = ST_ERROR;
        fb_d = 1'b1;
        cfg_pending_d = 1'b0;
      end
    end
  end

  // fault outputs registered with the mode, so they change on the same edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= ST_DEFAULT;
      cfg_pending_q <= 1'b0;
      class_a_fault_out <= 1'b0;
      class_b_fault_out <= 1'b0;
      turn_off_req <= TOFF_REGULAR;
    end else begin
      mode_q <= mode_d;
      cfg_pending_q <= cfg_pending_d;
      class_a_fault_out <= fa_d;
      class_b_fault_out <= fb_d;
      turn_off_req <= toff_d;
    end
  end

  // ***************************************************************
  // re-enable blocking window
  // ***************************************************************
  // a reset also counts as a turn-off, so the window opens from reset
  logic [15:0] block_q, block_d;
  always_comb begin
    block_d = block_q;
    if (toff_d != TOFF_NONE) begin
      block_d = 16'(REENABLE_BLOCK_CYCLES);
    end else if (block_q != 16'h0) begin
      block_d = block_q - 16'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      block_q <= 16'(REENABLE_BLOCK_CYCLES);
    end else begin
      block_q <= block_d;
    end
  end
  assign reenable_blocked = (block_q != 16'h0);

  // ***************************************************************
  // status flags
  // ***************************************************************
  // sticky: set wins over clear; configuration is not touched here
  flags_t flags_q, flags_d, set_v;
  always_comb begin
    set_v = '0;
    set_v.class_a_collector_saturation_fault = f.collector_saturation_fault;
    set_v.class_a_ocp = f.overcurrent_fault;
    set_v.class_a_enable_lost = en_fall;
    set_v.class_a_tristate = ev_tristate;
    set_v.class_b_supply = f.secondary_supply_undervoltage | f.secondary_supply_overvoltage
      | f.tertiary_supply_undervoltage | (f.tertiary_supply_overvoltage & tertiary_overvoltage_enable);
    set_v.class_b_supervision = f.supervision_error;
    set_v.class_b_verify_timeout = wd_expired;
    set_v.class_c_temperature = f.over_temperature_warning;
    set_v.class_c_spi = spi_err_d;
    set_v.class_c_shoot_through = f.shoot_through_error;
    flags_d = (clear_sticky_bit ? '0 : flags_q) | set_v;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
  assign status_flags = flags_q;

  // ***************************************************************
  // watchdog
  // ***************************************************************
  verify_watchdog #(
    .TIMEOUT_CYCLES(VERIFY_TIMEOUT_CYCLES)
  ) u_watchdog (
    .mclk(mclk),
    .rst(rst),
    .start(wd_start),
    .keep(mode_d == ST_VERIFICATION || mode_d == ST_WEAK_ACTIVE),
    .expired(wd_expired)
  );

  // ***************************************************************
  // output stage and status
  // ***************************************************************
  // gate driven only when enabled; tristate overrides everything
  logic gate_on_q, gate_weak_q, tri_q, ready_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      gate_on_q <= 1'b0;
      gate_weak_q <= 1'b0;
      tri_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      gate_on_q <= pwm_s && !ev_tristate && (mode_d == ST_ACTIVE);
      gate_weak_q <= pwm_s && !ev_tristate && (mode_d == ST_WEAK_ACTIVE);
      tri_q <= ev_tristate;
      ready_q <= !primary_reset;
    end
  end
  assign gate_on = gate_on_q;
  assign gate_weak = gate_weak_q;
  assign gate_tristate = tri_q;
  assign ready_out = ready_q;
  assign mode_field = 3'(mode_q);
endmodule

// *** src/opmode_consts.svh ***
/*
  Constants of the driver operating-mode block: command words, mode codes,
  and timing counts. Assumes a 100 MHz mclk.
*/
`ifndef OPMODE_CONSTS_SVH
`define OPMODE_CONSTS_SVH

// ***************************************************************
// command words
// ***************************************************************
`define CMD_ENTER_CFG 16'h1880
`define CMD_ENTER_VER 16'h1140
`define CMD_EXIT_CFG 16'h1220

// ***************************************************************
// mode field codes
// ***************************************************************
`define MODE_DEFAULT 3'h0
`define MODE_ERROR 3'h1
`define MODE_CONFIGURATION 3'h2
`define MODE_CONFIGURED 3'h3
`define MODE_ACTIVE 3'h4
`define MODE_VERIFICATION 3'h5
`define MODE_WEAK_ACTIVE 3'h6

// ***************************************************************
// timing
// ***************************************************************
`define MCLK_PERIOD_NS 10
`define REENABLE_BLOCK_CYCLES 256
`define VERIFY_TIMEOUT_US 1000
`define VERIFY_TIMEOUT_CYCLES ((`VERIFY_TIMEOUT_US * 1000) / `MCLK_PERIOD_NS)

`endif

// *** src/opmode_pkg.sv ***
/*
  Types shared by the operating-mode block.
  Assumes opmode_consts.svh is on the include path.
*/
package opmode_pkg;
  // raw fault and supply conditions, levels
  typedef struct packed {
    logic collector_saturation_fault;
    logic overcurrent_fault;
    logic stage_monitor_tristate;
    logic output_disable_input;
    logic secondary_supply_undervoltage;
    logic secondary_supply_overvoltage;
    logic tertiary_supply_undervoltage;
    logic tertiary_supply_overvoltage;
    logic supervision_error;
    logic over_temperature_warning;
    logic shoot_through_error;
  } fault_in_t;

  // sticky error flags shown to the host
  typedef struct packed {
    logic class_a_collector_saturation_fault;
    logic class_a_ocp;
    logic class_a_enable_lost;
    logic class_a_tristate;
    logic class_b_supply;
    logic class_b_supervision;
    logic class_b_verify_timeout;
    logic class_c_temperature;
    logic class_c_spi;
    logic class_c_shoot_through;
  } flags_t;

  typedef enum logic [1:0] {
    TOFF_NONE,
    TOFF_REGULAR,
    TOFF_SAFE
  } turn_off_t;
endpackage

// *** src/verify_watchdog.sv ***
/*
  Verification-mode watchdog: counts while armed, pulses on expiry.
  Assumes start is a one-cycle pulse from the mode machine in mclk domain.
*/
`timescale 1ns/1ps
`include "opmode_consts.svh"

module verify_watchdog #(
  parameter int TIMEOUT_CYCLES = `VERIFY_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic keep,
  output logic expired
);
  logic [31:0] count_q, count_d;
  logic run_q, run_d;
  logic expired_d;

  // ***************************************************************
  // counter
  // ***************************************************************
  // not restarted by keep; only start reloads, so weak active inherits time
  always_comb begin
    count_d = count_q;
    run_d = run_q;
    expired_d = 1'b0;
    if (start) begin
      count_d = 32'h0;
      run_d = 1'b1;
    end else if (run_q && !keep) begin
      run_d = 1'b0;
    end else if (run_q) begin
      if (count_q >= 32'(TIMEOUT_CYCLES - 1)) begin
        expired_d = 1'b1;
        run_d = 1'b0;
      end else begin
        count_d = count_q + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q <= 32'h0;
      run_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      count_q <= count_d;
      run_q <= run_d;
      expired <= expired_d;
    end
  end
endmodule

// *** tb/opmode_props.sv ***
/* checker for the operating-mode machine ports.
   assumes a bind onto driver_operating_mode_fsm, one mclk domain. */
`timescale 1ns/1ps
module opmode_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic primary_reset,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic class_a_fault_out,
  input wire logic class_b_fault_out,
  input wire logic ready_out,
  input wire logic gate_on,
  input wire opmode_pkg::turn_off_t turn_off_req,
  input wire logic [2:0] mode_field,
  input wire logic reenable_blocked
);
  import opmode_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ****************************************
  // properties
  // ****************************************
  // a class B win on the same edge is legal
  AST_CFG_IN: assert property (cmd_valid && cmd_word == 16'h1880 && mode_field == 3'h0
    |=> mode_field == 3'h2 || class_b_fault_out) else $error("enter config missed");
  AST_VER_IN: assert property (cmd_valid && cmd_word == 16'h1140 && mode_field == 3'h2
    |=> mode_field == 3'h5 || class_b_fault_out) else $error("enter verify missed");
  AST_MODE_RANGE: assert property (mode_field <= 3'h6) else $error("mode out of range");
  AST_A_LEAVES: assert property (class_a_fault_out |-> mode_field != 3'h4 && mode_field != 3'h6)
    else $error("class A left device enabled");
  AST_A_WITH: assert property (mode_field == 3'h3 && $past(mode_field) == 3'h4 |-> class_a_fault_out)
    else $error("active drop without class A pulse");
  AST_B_ONLY: assert property (class_b_fault_out |-> mode_field == 3'h1 && $past(mode_field) != 3'h1)
    else $error("class B pulse without transition");
  AST_B_WITH: assert property (mode_field == 3'h1 && $past(mode_field) != 3'h1 |-> class_b_fault_out)
    else $error("error entry without class B pulse");
  AST_ACT_ROUTE: assert property ($changed(mode_field) && mode_field == 3'h4 |-> $past(mode_field) == 3'h3)
    else $error("active entered from wrong mode");
  AST_GATE: assert property (gate_on |-> mode_field inside {3'h4, 3'h6} || $past(mode_field) inside {3'h4, 3'h6})
    else $error("gate on while disabled");
  AST_READY: assert property (!$past(rst) |-> ready_out == !$past(primary_reset))
    else $error("ready does not follow primary reset");
  AST_BLOCK: assert property (turn_off_req != TOFF_NONE |=> reenable_blocked)
    else $error("re-enable not blocked after turn-off");
endmodule
bind driver_operating_mode_fsm opmode_props chk_u (.mclk(mclk), .rst(rst), .primary_reset(primary_reset),
  .cmd_valid(cmd_valid), .cmd_word(cmd_word), .class_a_fault_out(class_a_fault_out),
  .class_b_fault_out(class_b_fault_out), .ready_out(ready_out), .gate_on(gate_on),
  .turn_off_req(turn_off_req), .mode_field(mode_field), .reenable_blocked(reenable_blocked));

// *** tb/host_model.sv ***
/* host controller model: mode command words and the enable pin.
   assumes mclk is the device clock; drives 1 ns after rising edges. */
`timescale 1ns/1ps
module host_model #(
  parameter int REENABLE_WAIT = 8
) (
  // clock
  input wire logic mclk,
  // host side
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  output logic enable_input
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'hFFFF;
    enable_input = 1'b0;
  end
  // one word a command; idle bus shows the inverse so stale data never matches
  task automatic send(input logic [15:0] w);
    @(posedge mclk);
    #1 cmd_valid = 1'b1;
    cmd_word = w;
    @(posedge mclk);
    #1 cmd_valid = 1'b0;
    cmd_word = ~w;
  endtask
  // invalid then valid, waiting out the turn-off block first
  task automatic arm();
    @(posedge mclk);
    #1 enable_input = 1'b0;
    repeat (REENABLE_WAIT + 4) @(posedge mclk);
    #1 enable_input = 1'b1;
  endtask
  task automatic drop();
    @(posedge mclk);
    #1 enable_input = 1'b0;
  endtask
endmodule

// *** tb/testbench.sv ***
/* self-checking bench for the operating-mode machine.
   assumes host_model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module testbench;
  import opmode_pkg::*;
  localparam int VTO = 50;
  localparam int RBC = 8;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic primary_reset = 1'b0;
  logic clear_sticky_bit = 1'b0;
  logic pwm_input = 1'b0;
  logic tertiary_overvoltage_enable = 1'b0;
  fault_in_t faults = '0;
  logic cmd_valid, enable_input, class_a_fault_out, class_b_fault_out, ready_out;
  logic gate_on, gate_weak, gate_tristate, reenable_blocked;
  logic [15:0] cmd_word;
  logic [2:0] mode_field;
  logic [2:0] m;
  logic [15:0] w;
  turn_off_t turn_off_req;
  turn_off_t last_toff = TOFF_NONE;
  flags_t status_flags;
  int bad_count = 0;
  int checks = 0;
  int a_cnt = 0;
  int b_cnt = 0;
  int a0;
  always #5 mclk = ~mclk;
  // pulses last one cycle, so tally them here
  always @(posedge mclk) begin
    if (class_a_fault_out === 1'b1) a_cnt <= a_cnt + 1;
    if (class_b_fault_out === 1'b1) b_cnt <= b_cnt + 1;
    if (turn_off_req !== TOFF_NONE) last_toff <= turn_off_req;
  end
  host_model #(.REENABLE_WAIT(RBC)) host_u (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .enable_input(enable_input));
  driver_operating_mode_fsm #(.VERIFY_TIMEOUT_CYCLES(VTO), .REENABLE_BLOCK_CYCLES(RBC)) dut_u (
    .mclk(mclk), .rst(rst), .primary_reset(primary_reset), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .clear_sticky_bit(clear_sticky_bit), .enable_input(enable_input), .pwm_input(pwm_input),
    .faults(faults), .tertiary_overvoltage_enable(tertiary_overvoltage_enable),
    .class_a_fault_out(class_a_fault_out), .class_b_fault_out(class_b_fault_out), .ready_out(ready_out),
    .gate_on(gate_on), .gate_weak(gate_weak), .gate_tristate(gate_tristate), .turn_off_req(turn_off_req),
    .mode_field(mode_field), .status_flags(status_flags), .reenable_blocked(reenable_blocked));
  // ****************************************
  // helpers
  // ****************************************
  // expected mode after a command word; anything else leaves the mode alone
  function automatic logic [2:0] cmd_mode(input logic [2:0] cur, input logic [15:0] cw);
    if (cw == 16'h1880 && (cur == 3'h0 || cur == 3'h1)) return 3'h2;
    if (cw == 16'h1220 && cur == 3'h2) return 3'h3;
    if (cw == 16'h1140 && cur == 3'h2) return 3'h5;
    return cur;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_mode(input logic [2:0] want, input int lim);
    int n;
    n = 0;
    while (mode_field !== want && n < lim) begin
      tick(1);
      n++;
    end
    chk("mode_field", 16'(want), 16'(mode_field));
    if (mode_field !== want) stop_test();
  endtask
  task automatic clear_flags();
    clear_sticky_bit = 1'b1;
    tick(1);
    clear_sticky_bit = 1'b0;
    tick(1);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(30));
    tick(16);
    rst = 1'b0;
    tick(1);
    chk("ready_out", 16'h1, 16'(ready_out));
    chk("mode_field", 16'h0, 16'(mode_field));
    chk("reenable_blocked", 16'h1, 16'(reenable_blocked));
    tick(RBC + 2);
    chk("reenable_blocked", 16'h0, 16'(reenable_blocked));
    // random words, legal and misplaced, with random pwm while disabled
    repeat (24) begin
      clear_flags();
      case ($urandom % 4)
        0: w = 16'h1880;
        1: w = 16'h1140;
        2: w = 16'h1220;
        default: w = 16'($urandom);
      endcase
      m = mode_field;
      pwm_input = 1'($urandom);
      host_u.send(w);
      tick(2);
      chk("mode_field", 16'(cmd_mode(m, w)), 16'(mode_field));
      chk("spi flag", 16'((w == 16'h1880 || w == 16'h1140 || w == 16'h1220) && cmd_mode(m, w) == m),
        16'(status_flags.class_c_spi));
      chk("gate_on", 16'h0, 16'(gate_on));
    end
    rst = 1'b1;
    primary_reset = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
    chk("mode_field", 16'h0, 16'(mode_field));
    chk("ready_out", 16'h0, 16'(ready_out));
    primary_reset = 1'b0;
    tick(RBC + 2);
    // configure, then enable into active mode
    host_u.send(16'h1880);
    host_u.send(16'h1220);
    wait_mode(3'h3, 4);
    host_u.arm();
    wait_mode(3'h4, 8);
    pwm_input = 1'b1;
    tick(4);
    chk("gate_on", 16'h1, 16'(gate_on));
    a0 = a_cnt;
    faults.collector_saturation_fault = 1'b1;
    wait_mode(3'h3, 8);
    tick(2);
    faults.collector_saturation_fault = 1'b0;
    chk("class A pulses", 16'h1, 16'(a_cnt - a0));
    chk("turn-off kind", 16'(TOFF_SAFE), 16'(last_toff));
    chk("collector_saturation_fault flag", 16'h1, 16'(status_flags.class_a_collector_saturation_fault));
    chk("gate_on", 16'h0, 16'(gate_on));
    // class A with no transition stays silent
    a0 = a_cnt;
    faults.overcurrent_fault = 1'b1;
    tick(6);
    faults.overcurrent_fault = 1'b0;
    chk("mode_field", 16'h3, 16'(mode_field));
    chk("class A pulses", 16'h0, 16'(a_cnt - a0));
    host_u.arm();
    wait_mode(3'h4, 8);
    host_u.drop();
    wait_mode(3'h3, 8);
    tick(1);
    chk("turn-off kind", 16'(TOFF_REGULAR), 16'(last_toff));
    chk("enable loss flag", 16'h1, 16'(status_flags.class_a_enable_lost));
    a0 = a_cnt;
    faults.output_disable_input = 1'b1;
    faults.over_temperature_warning = 1'b1;
    tick(6);
    chk("gate_tristate", 16'h1, 16'(gate_tristate));
    chk("tristate pulse", 16'h1, 16'(a_cnt != a0));
    faults.output_disable_input = 1'b0;
    faults.over_temperature_warning = 1'b0;
    chk("mode_field", 16'h3, 16'(mode_field));
    chk("tristate flag", 16'h1, 16'(status_flags.class_a_tristate));
    chk("temperature flag", 16'h1, 16'(status_flags.class_c_temperature));
    // tertiary overvoltage counts only when enabled
    faults.tertiary_supply_overvoltage = 1'b1;
    tick(6);
    chk("mode_field", 16'h3, 16'(mode_field));
    a0 = b_cnt;
    tertiary_overvoltage_enable = 1'b1;
    wait_mode(3'h1, 8);
    tick(1);
    chk("turn-off kind", 16'(TOFF_REGULAR), 16'(last_toff));
    chk("supply flag", 16'h1, 16'(status_flags.class_b_supply));
    clear_flags();
    host_u.send(16'h1880);
    tick(4);
    chk("mode_field", 16'h1, 16'(mode_field));
    chk("class B pulses", 16'h1, 16'(b_cnt - a0));
    faults.tertiary_supply_overvoltage = 1'b0;
    wait_mode(3'h2, 8);
    // verification, weak active, then the watchdog
    host_u.send(16'h1140);
    wait_mode(3'h5, 4);
    host_u.arm();
    wait_mode(3'h6, 8);
    tick(4);
    chk("gate_weak", 16'h1, 16'(gate_weak));
    wait_mode(3'h1, VTO + 20);
    chk("timeout flag", 16'h1, 16'(status_flags.class_b_verify_timeout));
    clear_flags();
    wait_mode(3'h0, 4);
    stop_test();
  end
endmodule
